/* logic/gpb_pkg.sv */
// Purpose: Constants and state type for the GPIO port bank
// Assumes: Avalon-MM byte addresses, one 32-bit word per register
// Notes: Only the low byte of each word carries data
package gpb_pkg;
    localparam int GPB_NPORT = 2;
    localparam int GPB_W = 8;
    // ==================================================
    // Register offsets
    localparam logic [7:0] GPB_OFF_P0_DATA = 8'h00;
    localparam logic [7:0] GPB_OFF_P0_DIR = 8'h04;
    localparam logic [7:0] GPB_OFF_P0_PULL = 8'h08;
    localparam logic [7:0] GPB_OFF_P0_LATCH = 8'h0c;
    localparam logic [7:0] GPB_OFF_P1_DATA = 8'h10;
    localparam logic [7:0] GPB_OFF_P1_DIR = 8'h14;
    localparam logic [7:0] GPB_OFF_P1_PULL = 8'h18;
    localparam logic [7:0] GPB_OFF_P1_LATCH = 8'h1c;
    localparam logic [7:0] GPB_OFF_CTRL = 8'h20;
    localparam logic [7:0] GPB_PORT_STRIDE = 8'h10;
    // ==================================================
    // Control register fields and reset values
    localparam int GPB_CTRL_FLOAT_BIT = 0;
    localparam int GPB_CTRL_ROUTE_BIT = 1;
    localparam logic [1:0] GPB_CTRL_RST = 2'h0;
    localparam logic [7:0] GPB_PORT_RST = 8'h00;
    // ==================================================
    // Pin positions on port 1
    localparam int GPB_P1_RX_BIT = 0;
    localparam int GPB_P1_DBG_BIT = 2;
    localparam int GPB_P1_SCK_BIT = 3;
    // ==================================================
    // Whole state of the bank
    typedef struct packed {
        logic [GPB_NPORT-1:0][GPB_W-1:0] latch;
        logic [GPB_NPORT-1:0][GPB_W-1:0] dir;
        logic [GPB_NPORT-1:0][GPB_W-1:0] pull;
        logic [GPB_NPORT-1:0][GPB_W-1:0] sync1;
        logic [GPB_NPORT-1:0][GPB_W-1:0] sync2;
        logic p83_sync1;
        logic p83_sync2;
        logic [1:0] ctrl;
        logic [GPB_NPORT-1:0][GPB_W-1:0] pin_out;
        logic [GPB_NPORT-1:0][GPB_W-1:0] pin_oe;
        logic [GPB_NPORT-1:0][GPB_W-1:0] pin_pu;
        logic [GPB_W-1:0] irq;
        logic rx;
        logic sck;
        logic dbg;
        logic trg;
        logic adtrg;
        logic wait_req;
        logic [31:0] rdata;
    } gpb_state_t;
    localparam gpb_state_t GPB_STATE_RST = '{
        latch: '0, dir: '0, pull: '0, sync1: '0, sync2: '0,
        p83_sync1: 1'b0, p83_sync2: 1'b0, ctrl: GPB_CTRL_RST,
        pin_out: '0, pin_oe: '0, pin_pu: '0, irq: 8'h00,
        rx: 1'b0, sck: 1'b0, dbg: 1'b0, trg: 1'b0, adtrg: 1'b0,
        wait_req: 1'b1, rdata: 32'h0000_0000};
endpackage : gpb_pkg

/* logic/gpb_port_bank.sv */
// Purpose: GPIO ports 0 and 1 with data latch, direction and pull-up
// Assumes: Single clock; pins synchronised by two flip-flops
// Notes: Latch offset is the read-modify-write view of the data
//
// Our own choices: the Avalon-MM interface to the registers and the register offsets.
`timescale 1ns/10ps
`default_nettype none
module gpb_port_bank (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic resetn,
    // Avalon-MM slave
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // Port 0 pins
    input wire logic [gpb_pkg::GPB_W-1:0] port0_pin_in,
    output logic [gpb_pkg::GPB_W-1:0] port0_pin_out,
    output logic [gpb_pkg::GPB_W-1:0] port0_pin_oe,
    output logic [gpb_pkg::GPB_W-1:0] port0_pin_pullup,
    // Port 1 pins
    input wire logic [gpb_pkg::GPB_W-1:0] port1_pin_in,
    output logic [gpb_pkg::GPB_W-1:0] port1_pin_out,
    output logic [gpb_pkg::GPB_W-1:0] port1_pin_oe,
    output logic [gpb_pkg::GPB_W-1:0] port1_pin_pullup,
    // Alternate trigger pin
    input wire logic port8_pin3_in,
    // Standby and wake control
    input wire logic standby_stop_watch,
    input wire logic [gpb_pkg::GPB_W-1:0] port0_wake_en,
    input wire logic [gpb_pkg::GPB_W-1:0] port1_wake_en,
    // Peripheral outputs on port 1
    input wire logic [gpb_pkg::GPB_W-1:0] port1_periph_oe,
    input wire logic [gpb_pkg::GPB_W-1:0] port1_periph_out,
    // Peripheral and interrupt inputs
    output logic [gpb_pkg::GPB_W-1:0] ext_irq_input,
    output logic serial_rx_in,
    output logic serial_clock_in,
    output logic debug_wire_in,
    output logic pulse_timer_trigger_in,
    output logic converter_trigger_in
);
    import gpb_pkg::*;

    gpb_state_t st_q;
    gpb_state_t st_d;
    logic float_act;
    logic [GPB_NPORT-1:0][GPB_W-1:0] gated;

    // ==================================================
    // Next state
    always_comb begin
        logic [GPB_NPORT-1:0][GPB_W-1:0] wake;
        logic [GPB_NPORT-1:0][GPB_W-1:0] p_oe;
        logic [GPB_NPORT-1:0][GPB_W-1:0] p_out;
        logic [GPB_W-1:0] drv_out;
        logic [GPB_W-1:0] oe_d;
        logic [GPB_W-1:0] view;
        logic port_sel;
        logic hit;
        wake = '0;
        p_oe = '0;
        p_out = '0;
        drv_out = '0;
        oe_d = '0;
        view = '0;
        port_sel = 1'b0;
        hit = 1'b0;
        st_d = st_q;
        wake[0] = port0_wake_en;
        wake[1] = port1_wake_en;
        p_oe[1] = port1_periph_oe;
        p_out[1] = port1_periph_out;
        // Pin synchronisers
        st_d.sync1[0] = port0_pin_in;
        st_d.sync1[1] = port1_pin_in;
        st_d.sync2 = st_q.sync1;
        st_d.p83_sync1 = port8_pin3_in;
        st_d.p83_sync2 = st_q.p83_sync1;
        float_act = st_q.ctrl[GPB_CTRL_FLOAT_BIT] & standby_stop_watch;
        // Pin drive per port
        for (int p = 0; p < GPB_NPORT; p++) begin
            gated[p] = float_act ? (st_q.sync2[p] & wake[p]) : st_q.sync2[p];
            drv_out = (p_oe[p] & p_out[p]) | (~p_oe[p] & st_q.latch[p]);
            oe_d = float_act ? '0 : (st_q.dir[p] | p_oe[p]);
            st_d.pin_out[p] = drv_out;
            st_d.pin_oe[p] = oe_d;
            st_d.pin_pu[p] = st_q.pull[p] & ~(oe_d & ~drv_out);
        end
        // Peripheral and interrupt inputs
        st_d.irq = gated[0];
        st_d.rx = gated[1][GPB_P1_RX_BIT];
        st_d.dbg = gated[1][GPB_P1_DBG_BIT];
        st_d.sck = gated[1][GPB_P1_SCK_BIT];
        st_d.trg = st_q.ctrl[GPB_CTRL_ROUTE_BIT] ? st_q.p83_sync2 : gated[1][GPB_P1_SCK_BIT];
        st_d.adtrg = st_d.trg;
        // Bus slave: one wait state, then answer
        port_sel = avs_address[4];
        hit = avs_address < (GPB_OFF_CTRL + 8'h04);
        st_d.wait_req = 1'b1;
        if ((avs_read || avs_write) && st_q.wait_req) begin
            st_d.wait_req = 1'b0;
            st_d.rdata = 32'h0000_0000;
            if (avs_read && hit) begin
                if (avs_address == GPB_OFF_CTRL) begin
                    st_d.rdata[1:0] = st_q.ctrl;
                end else begin
                    case (avs_address[3:0])
                        4'h0: view = (st_q.dir[port_sel] & st_q.latch[port_sel])
                            | (~st_q.dir[port_sel] & gated[port_sel]);
                        4'h4: view = st_q.dir[port_sel];
                        4'h8: view = st_q.pull[port_sel];
                        4'hc: view = st_q.latch[port_sel];
                        default: view = '0;
                    endcase
                    st_d.rdata[7:0] = view;
                end
            end
        end
        if (avs_write && !st_q.wait_req && avs_byteenable[0] && hit) begin
            if (avs_address == GPB_OFF_CTRL) begin
                st_d.ctrl = avs_writedata[1:0];
            end else begin
                case (avs_address[3:0])
                    4'h0: st_d.latch[port_sel] = avs_writedata[7:0];
                    4'h4: st_d.dir[port_sel] = avs_writedata[7:0];
                    4'h8: st_d.pull[port_sel] = avs_writedata[7:0];
                    4'hc: st_d.latch[port_sel] = avs_writedata[7:0];
                    default: st_d.latch = st_q.latch;
                endcase
            end
        end
    end

    // ==================================================
    // State register
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            st_q <= GPB_STATE_RST;
        end else begin
            st_q <= st_d;
        end
    end

    // ==================================================
    // Outputs
    assign avs_readdata = st_q.rdata;
    assign avs_waitrequest = st_q.wait_req;
    assign port0_pin_out = st_q.pin_out[0];
    assign port0_pin_oe = st_q.pin_oe[0];
    assign port0_pin_pullup = st_q.pin_pu[0];
    assign port1_pin_out = st_q.pin_out[1];
    assign port1_pin_oe = st_q.pin_oe[1];
    assign port1_pin_pullup = st_q.pin_pu[1];
    assign ext_irq_input = st_q.irq;
    assign serial_rx_in = st_q.rx;
    assign serial_clock_in = st_q.sck;
    assign debug_wire_in = st_q.dbg;
    assign pulse_timer_trigger_in = st_q.trg;
    assign converter_trigger_in = st_q.adtrg;

    // ==================================================
    // Checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);

    a_dir_sets_oe: assert property (!float_act |=> port0_pin_oe == $past(st_q.dir[0]))
        else $error("port0 enable differs from direction");
    a_out_drives_latch: assert property (!float_act
        |=> ((port0_pin_out ^ $past(st_q.latch[0])) & port0_pin_oe) == 8'h00)
        else $error("port0 output differs from latch");
    a_write_reaches_pin: assert property (avs_write && !avs_waitrequest && avs_byteenable[0]
        && avs_address == GPB_OFF_P0_DATA && st_q.dir[0] == 8'hff && !float_act && !standby_stop_watch
        |=> ##1 port0_pin_out == $past(avs_writedata[7:0], 2))
        else $error("written data not on output pins");
    a_input_not_driven: assert property (avs_write && !avs_waitrequest
        && avs_address == GPB_OFF_P0_DATA && st_q.dir[0] == 8'h00 && $stable(st_q.dir[0])
        |=> ##1 port0_pin_oe == 8'h00)
        else $error("input pin driven after data write");
    a_read_mix: assert property (avs_read && avs_waitrequest && avs_address == GPB_OFF_P1_DATA
        |=> avs_readdata[7:0] == (($past(st_q.dir[1]) & $past(st_q.latch[1]))
        | (~$past(st_q.dir[1]) & $past(gated[1]))))
        else $error("data read mixes latch and pin wrongly");
    a_rmw_latch: assert property (avs_read && avs_waitrequest && avs_address == GPB_OFF_P0_LATCH
        |=> avs_readdata == {24'h000000, $past(st_q.latch[0])})
        else $error("latch view does not return latch");
    a_reset_clear: assert property (!$past(resetn)
        |-> st_q.dir == '0 && st_q.latch == '0 && st_q.pull == '0)
        else $error("registers not cleared by reset");
    a_float_hiz: assert property (float_act |=> port0_pin_oe == 8'h00 && port1_pin_oe == 8'h00)
        else $error("pin driven while floated");
    a_float_gate: assert property (float_act
        |=> (ext_irq_input & ~$past(port0_wake_en)) == 8'h00)
        else $error("disabled input not gated low");
    a_irq_forward: assert property (!float_act |=> ext_irq_input == $past(st_q.sync2[0]))
        else $error("port0 level not forwarded");
    a_pullup_off_low: assert property ((port1_pin_pullup & port1_pin_oe & ~port1_pin_out) == 8'h00)
        else $error("pull-up on while driving low");
    a_trigger_route: assert property (!st_q.ctrl[GPB_CTRL_ROUTE_BIT] && !float_act
        |=> pulse_timer_trigger_in == $past(st_q.sync2[1][GPB_P1_SCK_BIT]))
        else $error("trigger not taken from port1 pin3");

    // ==================================================
    // Pin drive checks

    a_p1_dir_oe: assert property (!float_act
        |=> port1_pin_oe == ($past(st_q.dir[1]) | $past(port1_periph_oe)))
        else $error("port1 enable differs from direction");

    a_p1_out_latch: assert property (!float_act
        |=> ((port1_pin_out ^ $past(st_q.latch[1])) & ~$past(port1_periph_oe)) == 8'h00)
        else $error("port1 output differs from latch");

    a_p1_input_hiz: assert property (st_q.dir[1] == 8'h00 && port1_periph_oe == 8'h00
        |=> port1_pin_oe == 8'h00)
        else $error("port1 input pin driven");

    a_p0_pull_on: assert property (1'b1
        |=> port0_pin_pullup == ($past(st_q.pull[0]) & ~(port0_pin_oe & ~port0_pin_out)))
        else $error("port0 pull-up differs from register");

    a_p1_pull_on: assert property (1'b1
        |=> port1_pin_pullup == ($past(st_q.pull[1]) & ~(port1_pin_oe & ~port1_pin_out)))
        else $error("port1 pull-up differs from register");

    a_p0_pull_low: assert property (
        (port0_pin_pullup & port0_pin_oe & ~port0_pin_out) == 8'h00)
        else $error("port0 pull-up on while driving low");

    a_reset_oe: assert property (!$past(resetn)
        |-> port0_pin_oe == 8'h00 && port1_pin_oe == 8'h00)
        else $error("pin driven right after reset");

    a_hold_p0_oe: assert property (!st_q.ctrl[GPB_CTRL_FLOAT_BIT] && standby_stop_watch
        |=> port0_pin_oe == $past(st_q.dir[0]))
        else $error("port0 drive lost in standby");

    a_hold_p1_oe: assert property (!st_q.ctrl[GPB_CTRL_FLOAT_BIT] && standby_stop_watch
        |=> port1_pin_oe == ($past(st_q.dir[1]) | $past(port1_periph_oe)))
        else $error("port1 drive lost in standby");

    // ==================================================
    // Input path checks

    a_wake_passes: assert property (float_act
        |=> ext_irq_input == ($past(st_q.sync2[0]) & $past(port0_wake_en)))
        else $error("enabled interrupt input blocked");

    a_rx_gate: assert property (float_act
        |=> !serial_rx_in || $past(port1_wake_en[GPB_P1_RX_BIT]))
        else $error("receive input not gated");

    a_dbg_gate: assert property (float_act
        |=> !debug_wire_in || $past(port1_wake_en[GPB_P1_DBG_BIT]))
        else $error("debug input not gated");

    a_sck_gate: assert property (float_act
        |=> !serial_clock_in || $past(port1_wake_en[GPB_P1_SCK_BIT]))
        else $error("serial clock input not gated");

    a_rx_forward: assert property (!float_act
        |=> serial_rx_in == $past(st_q.sync2[1][GPB_P1_RX_BIT]))
        else $error("receive input not forwarded");

    a_dbg_forward: assert property (!float_act
        |=> debug_wire_in == $past(st_q.sync2[1][GPB_P1_DBG_BIT]))
        else $error("debug input not forwarded");

    a_sck_forward: assert property (!float_act
        |=> serial_clock_in == $past(st_q.sync2[1][GPB_P1_SCK_BIT]))
        else $error("serial clock not forwarded");

    a_route_alt: assert property (st_q.ctrl[GPB_CTRL_ROUTE_BIT]
        |=> pulse_timer_trigger_in == $past(st_q.p83_sync2))
        else $error("trigger not taken from alternate pin");

    a_adc_route: assert property (
        converter_trigger_in == pulse_timer_trigger_in)
        else $error("converter trigger differs from timer trigger");

    // ==================================================
    // Register bus checks

    a_p0_in_read: assert property (avs_read && avs_waitrequest && avs_address == GPB_OFF_P0_DATA
        |=> ((avs_readdata[7:0] ^ $past(gated[0])) & ~$past(st_q.dir[0])) == 8'h00)
        else $error("input pin read wrong");

    a_p0_out_read: assert property (avs_read && avs_waitrequest && avs_address == GPB_OFF_P0_DATA
        |=> ((avs_readdata[7:0] ^ $past(st_q.latch[0])) & $past(st_q.dir[0])) == 8'h00)
        else $error("output pin read wrong");

    a_p1_latch_read: assert property (avs_read && avs_waitrequest && avs_address == GPB_OFF_P1_LATCH
        |=> avs_readdata == {24'h000000, $past(st_q.latch[1])})
        else $error("port1 latch view wrong");

    a_dir_read: assert property (avs_read && avs_waitrequest && avs_address == GPB_OFF_P0_DIR
        |=> avs_readdata == {24'h000000, $past(st_q.dir[0])})
        else $error("direction read wrong");

    a_pull_read: assert property (avs_read && avs_waitrequest && avs_address == GPB_OFF_P1_PULL
        |=> avs_readdata == {24'h000000, $past(st_q.pull[1])})
        else $error("pull-up read wrong");

    a_ctrl_read: assert property (avs_read && avs_waitrequest && avs_address == GPB_OFF_CTRL
        |=> avs_readdata == {30'h00000000, $past(st_q.ctrl)})
        else $error("control read wrong");

    a_refused_read: assert property (avs_read && avs_waitrequest && avs_address >= (GPB_OFF_CTRL + 8'h04)
        |=> avs_readdata == 32'h0000_0000)
        else $error("unmapped read not zero");

    a_wait_one: assert property (!avs_waitrequest
        |=> avs_waitrequest)
        else $error("answer longer than one cycle");

    a_dir_lands: assert property (avs_write && !avs_waitrequest && avs_byteenable[0] && avs_address == GPB_OFF_P1_DIR
        |=> st_q.dir[1] == $past(avs_writedata[7:0]))
        else $error("direction write lost");

    a_latch_lands: assert property (avs_write && !avs_waitrequest && avs_byteenable[0] && avs_address == GPB_OFF_P1_DATA
        |=> st_q.latch[1] == $past(avs_writedata[7:0]))
        else $error("data write lost");

    a_pull_lands: assert property (avs_write && !avs_waitrequest && avs_byteenable[0] && avs_address == GPB_OFF_P0_PULL
        |=> st_q.pull[0] == $past(avs_writedata[7:0]))
        else $error("pull-up write lost");

    a_be_refused: assert property (avs_write && !avs_waitrequest && !avs_byteenable[0]
        |=> $stable(st_q.dir) && $stable(st_q.latch) && $stable(st_q.pull))
        else $error("write without byte enable changed a register");
endmodule : gpb_port_bank
`default_nettype wire

/* tb/gpb_pin_model.sv */
// Purpose: External pin model for one 8-bit port
// Assumes: Bank drive wins, then outside source, then pull-up
// Notes: A floating pin shows the inverse of the outside value
`timescale 1ns/10ps
`default_nettype none
module gpb_pin_model (
    // Bank side
    input wire logic [7:0] pin_out,
    input wire logic [7:0] pin_oe,
    input wire logic [7:0] pin_pu,
    // Outside source
    input wire logic [7:0] ext_en,
    input wire logic [7:0] ext_val,
    // Level at the pin
    output logic [7:0] level
);
    // ==================================================
    // Pin resolution
    assign level = (pin_oe & pin_out) | (~pin_oe & ((ext_en & ext_val) | (~ext_en & (pin_pu | ~ext_val))));
endmodule : gpb_pin_model
`default_nettype wire

/* tb/tb.sv */
// Purpose: Self-checking bench for the GPIO port bank
// Assumes: Avalon master waits for waitrequest low
// Notes: Random pins and registers from a fixed seed
`timescale 1ns/10ps
`default_nettype none
module tb;
    import gpb_pkg::*;
    logic clk_sys = 1'b0, resetn = 1'b0, avs_read = 1'b0, avs_write = 1'b0, avs_waitrequest;
    logic [7:0] avs_address = 8'h00, port0_wake_en = '0, port1_wake_en = '0;
    logic [31:0] avs_writedata = '0, avs_readdata, seed;
    logic [3:0] avs_byteenable = 4'hf;
    logic port8_pin3_in = 1'b0, standby_stop_watch = 1'b0;
    logic [7:0] port1_periph_oe = '0, port1_periph_out = '0, ext_irq_input, en = 8'hff, d, l, u, w;
    logic [7:0] pin [2], pout [2], poe [2], ppu [2];
    logic [7:0] ev [2] = '{8'h00, 8'h00};
    logic serial_rx_in, serial_clock_in, debug_wire_in, pulse_timer_trigger_in, converter_trigger_in;
    int n_errors = 0, total_checks = 0;
    always #4 clk_sys = ~clk_sys;
    // ==================================================
    // Design and pins
    gpb_port_bank u_gpb_port_bank (.clk_sys, .resetn, .avs_address, .avs_read, .avs_write, .avs_writedata,
        .avs_byteenable, .avs_readdata, .avs_waitrequest, .port0_pin_in(pin[0]), .port0_pin_out(pout[0]),
        .port0_pin_oe(poe[0]), .port0_pin_pullup(ppu[0]), .port1_pin_in(pin[1]), .port1_pin_out(pout[1]),
        .port1_pin_oe(poe[1]), .port1_pin_pullup(ppu[1]), .port8_pin3_in, .standby_stop_watch,
        .port0_wake_en, .port1_wake_en, .port1_periph_oe, .port1_periph_out, .ext_irq_input,
        .serial_rx_in, .serial_clock_in, .debug_wire_in, .pulse_timer_trigger_in, .converter_trigger_in);
    for (genvar p = 0; p < 2; p++) begin : g_pin
        gpb_pin_model u_gpb_pin_model (.pin_out(pout[p]), .pin_oe(poe[p]), .pin_pu(ppu[p]), .ext_en(en),
            .ext_val(ev[p]), .level(pin[p]));
    end
    // ==================================================
    // Helpers
    function automatic logic [7:0] pexp(input logic [7:0] dd, ll, uu, ee);
        return (dd & ll) | (~dd & ((en & ee) | (~en & (uu | ~ee))));
    endfunction : pexp
    task automatic bus(input logic w1, input logic [7:0] a, input logic [7:0] v, output logic [31:0] r);
        int n;
        n = 0;
        @(posedge clk_sys);
        avs_address <= a;
        avs_writedata <= {24'h0, v};
        avs_write <= w1;
        avs_read <= ~w1;
        @(posedge clk_sys);
        while (avs_waitrequest !== 1'b0 && n < 40) begin
            @(posedge clk_sys);
            n++;
        end
        if (n >= 40) n_errors++;
        r = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask : bus
    task automatic chk(input logic [31:0] g, e, input string m);
        total_checks++;
        if (g !== e) begin
            n_errors++;
            $display("CHECK FAILED at %0t: %s got %h exp %h", $time, m, g, e);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, v);
        logic [31:0] r;
        bus(1'b1, a, v, r);
    endtask : wr
    task automatic rdc(input logic [7:0] a, e, input string m);
        logic [31:0] r;
        bus(1'b0, a, 8'h00, r);
        chk(r, {24'h0, e}, m);
    endtask : rdc
    task automatic settle();
        repeat (4) @(posedge clk_sys);
        @(negedge clk_sys);
    endtask : settle
    task automatic final_report();
        if (n_errors == 0 && total_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : final_report
    initial begin
        repeat (20000) @(posedge clk_sys);
        n_errors++;
        final_report();
    end
    // ==================================================
    // Main sequence
    initial begin
        seed = $urandom(65);
        repeat (16) @(posedge clk_sys);
        resetn <= 1'b1;
        wr(8'h24, 8'hff);
        avs_byteenable <= 4'h0;
        wr(8'h04, 8'hff);
        avs_byteenable <= 4'hf;
        for (int a = 0; a <= 36; a += 4) rdc(8'(a), 8'h00, "reset or refused");
        for (int it = 0; it < 12; it++) begin
            d = (it == 0) ? 8'hff : (it == 1) ? 8'h00 : 8'($urandom);
            l = (it == 0) ? 8'h00 : 8'($urandom);
            u = (it == 0) ? 8'hff : 8'($urandom);
            @(posedge clk_sys);
            en <= (it < 2) ? 8'hff : 8'($urandom);
            ev[0] <= 8'($urandom);
            ev[1] <= 8'($urandom);
            for (int p = 0; p < 2; p++) begin
                wr(8'(p * 16 + 4), d);
                wr(8'(p * 16), l);
                wr(8'(p * 16 + 8), u);
            end
            settle();
            chk(ext_irq_input, pexp(d, l, u, ev[0]), "irq level");
            for (int p = 0; p < 2; p++) begin
                w = pexp(d, l, u, ev[p]);
                chk(poe[p], d, "direction");
                chk(pin[p], w, "pin level");
                chk(ppu[p], u & ~(d & ~l), "pull-up");
                rdc(8'(p * 16), w, "data read");
                rdc(8'(p * 16 + 12), l, "latch read");
            end
            chk({serial_clock_in, debug_wire_in, serial_rx_in}, {w[3], w[2], w[0]}, "periph in");
        end
        wr(8'h14, 8'h00);
        @(posedge clk_sys);
        port1_periph_oe <= 8'h02;
        port1_periph_out <= 8'h02;
        settle();
        rdc(8'h10, pexp(8'h02, 8'h02, u, ev[1]), "periph pin read");
        rdc(8'h1c, l, "periph latch read");
        port1_periph_oe <= 8'h00;
        wr(8'h20, 8'h02);
        for (int b = 0; b < 2; b++) begin
            @(posedge clk_sys);
            port8_pin3_in <= 1'(b);
            settle();
            chk({pulse_timer_trigger_in, converter_trigger_in}, {2{1'(b)}}, "alt trigger");
        end
        wr(8'h20, 8'h00);
        settle();
        chk({pulse_timer_trigger_in, converter_trigger_in}, {2{pin[1][3]}}, "pin trigger");
        for (int p = 0; p < 2; p++) begin
            wr(8'(p * 16 + 4), 8'hff);
            wr(8'(p * 16), 8'ha5);
        end
        port0_wake_en <= 8'h0f;
        en <= 8'hff;
        wr(8'h20, 8'h01);
        standby_stop_watch <= 1'b1;
        settle();
        chk({poe[0], poe[1]}, 16'h0000, "float oe");
        chk(ext_irq_input, ev[0] & 8'h0f, "float irq");
        chk({serial_rx_in, debug_wire_in, serial_clock_in}, 3'h0, "float gate");
        @(posedge clk_sys);
        standby_stop_watch <= 1'b0;
        wr(8'h20, 8'h00);
        standby_stop_watch <= 1'b1;
        settle();
        chk({poe[1], pin[0]}, 16'hffa5, "standby hold");
        final_report();
    end
endmodule : tb
`default_nettype wire
